// file: verilog/sr_wave_output.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sr_wave_params.svh"

module sr_wave_output #(
  parameter logic [15:0] PRESCALE = `SRW_PRESCALE_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [15:0] rdata,
  input wire logic [7:0] comparePinIn,
  output logic [7:0] comparePinOut,
  output logic [7:0] comparePinOe,
  output logic irq
);

  sr_wave_pkg::state_t st;
  sr_wave_pkg::state_t next_st;
  sr_wave_pkg::reset_src_t resetSrc;
  logic tick;
  logic timerClear;
  logic [7:0] hit;
  logic [3:0] pairRun;
  logic [3:0] pairLevel;
  logic [3:0] pairSelected;
  logic [7:0] srChannel;
  logic [7:0] flagSet;
  logic [7:0] flagClear;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic isSrMode(
    input logic enable,
    input logic select,
    input logic [1:0] kind
  );
    return enable && !select && (kind == `SRW_MODE_SR); // see [R14]
  endfunction : isSrMode

  function automatic sr_wave_pkg::reset_src_t decodeResetSrc(
    input sr_wave_pkg::timer_ctrl_t c
  );
    if (c.resetOnChannelZero && !c.resetSelectMid && !c.resetOnReloadMatch) begin
      return sr_wave_pkg::SRC_CH0; // see [R5]
    end
    if (c.resetOnReloadMatch && !c.resetSelectMid && !c.resetOnChannelZero) begin
      return sr_wave_pkg::SRC_RELOAD; // see [R5]
    end
    return sr_wave_pkg::SRC_FREE; // see [R3]
  endfunction : decodeResetSrc

  function automatic logic [15:0] readMux(
    input logic [4:0] a,
    input sr_wave_pkg::state_t s
  );
    logic [15:0] v;
    v = 16'h0000;
    if (a[4:3] == 2'h2) begin
      v = s.regs.matchValue[a[2:0]];
    end else begin
      case (a)
        `SRW_OFS_TIMER_CTRL: begin
          v = {12'h000, s.regs.timerControl};
        end
        `SRW_OFS_RESET_VALUE: begin
          v = s.regs.timerResetValue;
        end
        `SRW_OFS_FUNC_EN: begin
          v = {8'h00, s.regs.channelFunctionEnables};
        end
        `SRW_OFS_FUNC_SEL: begin
          v = {8'h00, s.regs.functionSelectReg};
        end
        `SRW_OFS_MODE: begin
          v = s.regs.waveformKind;
        end
        `SRW_OFS_OUT_CTRL: begin
          v = s.regs.channelOutputControl;
        end
        `SRW_OFS_FLAGS: begin
          v = {8'h00, s.regs.matchRequestFlags};
        end
        `SRW_OFS_MASK: begin
          v = {8'h00, s.regs.flagMask};
        end
        `SRW_OFS_TIMER: begin
          v = s.timer;
        end
        `SRW_OFS_PORT_DATA: begin
          v = {8'h00, s.regs.portData};
        end
        `SRW_OFS_PORT_DIR: begin
          v = {8'h00, s.regs.portDir};
        end
        `SRW_OFS_PIN_IN: begin
          v = {8'h00, s.pinSync2};
        end
        default: begin
          v = 16'h0000;
        end
      endcase
    end
    return v;
  endfunction : readMux

  ////////////////////////////////////////////////////////////////////////////////
  // Count clock divider and timer control
  assign resetSrc = decodeResetSrc(st.regs.timerControl);
  assign tick = st.regs.timerControl.countEnable && (st.divCount == (PRESCALE - 16'h0001));

  always_comb begin
    timerClear = 1'b0;
    case (resetSrc)
      sr_wave_pkg::SRC_CH0: begin
        timerClear = (st.timer == (st.regs.matchValue[0] + 16'h0001)); // see [R5]
      end
      sr_wave_pkg::SRC_RELOAD: begin
        timerClear = (st.timer == (st.regs.timerResetValue + 16'h0001)); // see [R5]
      end
      sr_wave_pkg::SRC_FREE: begin
        timerClear = 1'b0; // see [R3]
      end
      default: begin
        timerClear = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel pairs
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      srChannel[i] = isSrMode(st.regs.channelFunctionEnables[i],
        st.regs.functionSelectReg[i], st.regs.waveformKind[2*i +: 2]);
    end
    for (int p = 0; p < 4; p++) begin
      pairSelected[p] = srChannel[2*p] && srChannel[2*p+1];
    end
    if (resetSrc == sr_wave_pkg::SRC_CH0) begin
      pairSelected[0] = 1'b0; // see [R8]
    end
  end

  for (genvar g = 0; g < 4; g++) begin : gen_pair
    sr_pair u_pair (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .timer(st.timer),
      .evenMatchValue(st.regs.matchValue[2*g]),
      .oddMatchValue(st.regs.matchValue[2*g+1]),
      .evenEnable(st.regs.channelFunctionEnables[2*g]),
      .oddEnable(st.regs.channelFunctionEnables[2*g+1]),
      .srSelected(pairSelected[g]),
      .startLevel(st.regs.channelOutputControl.startLevelSelect[2*g]),
      .evenHit(hit[2*g]),
      .oddHit(hit[2*g+1]),
      .run(pairRun[g]),
      .level(pairLevel[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags
  always_comb begin
    flagSet = hit & st.regs.channelFunctionEnables; // see [R10]
    flagClear = 8'h00;
    if (writeStrobe && (addr == `SRW_OFS_FLAGS)) begin
      flagClear = wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;

    // Input pins pass two flops
    next_st.pinSync1 = comparePinIn;
    next_st.pinSync2 = st.pinSync1;

    // Divider and up counter
    if (!st.regs.timerControl.countEnable || tick) begin
      next_st.divCount = 16'h0000;
    end else begin
      next_st.divCount = st.divCount + 16'h0001;
    end
    if (tick) begin
      if (timerClear) begin
        next_st.timer = 16'h0000; // see [R5]
      end else begin
        next_st.timer = st.timer + 16'h0001; // see [R15] [R3]
      end
    end

    // Register writes
    if (writeStrobe) begin
      if (addr[4:3] == 2'h2) begin
        next_st.regs.matchValue[addr[2:0]] = wdata;
      end else begin
        case (addr)
          `SRW_OFS_TIMER_CTRL: begin
            next_st.regs.timerControl = wdata[3:0];
          end
          `SRW_OFS_RESET_VALUE: begin
            next_st.regs.timerResetValue = wdata;
          end
          `SRW_OFS_FUNC_EN: begin
            next_st.regs.channelFunctionEnables = wdata[7:0];
          end
          `SRW_OFS_FUNC_SEL: begin
            next_st.regs.functionSelectReg = wdata[7:0];
          end
          `SRW_OFS_MODE: begin
            next_st.regs.waveformKind = wdata;
          end
          `SRW_OFS_OUT_CTRL: begin
            next_st.regs.channelOutputControl = wdata;
          end
          `SRW_OFS_MASK: begin
            next_st.regs.flagMask = wdata[7:0];
          end
          `SRW_OFS_PORT_DATA: begin
            next_st.regs.portData = wdata[7:0];
          end
          `SRW_OFS_PORT_DIR: begin
            next_st.regs.portDir = wdata[7:0];
          end
          default: begin
          end
        endcase
      end
    end

    // Set wins over a write-one clear
    next_st.regs.matchRequestFlags = (st.regs.matchRequestFlags & ~flagClear) | flagSet;
    next_st.irq = |(next_st.regs.matchRequestFlags & next_st.regs.flagMask);

    // Pin roles
    for (int i = 0; i < 8; i++) begin
      next_st.pins.out[i] = st.regs.portData[i]; // see [R13] [R12]
      next_st.pins.oe[i] = st.regs.portDir[i]; // see [R13] [R12]
    end
    for (int p = 0; p < 4; p++) begin
      if (pairRun[p]) begin
        next_st.pins.out[2*p] = pairLevel[p]
          ^ st.regs.channelOutputControl.polarityFlip[2*p]; // see [R11]
        next_st.pins.oe[2*p] = 1'b1; // see [R12]
      end
    end

    // Read data, one cycle only
    if (readStrobe) begin
      next_st.rdata = readMux(addr, st);
    end else begin
      next_st.rdata = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.regs.timerControl <= `SRW_RESET_CTRL;
      st.regs.timerResetValue <= `SRW_RESET_WORD;
      st.regs.channelFunctionEnables <= `SRW_RESET_BYTE;
      st.regs.functionSelectReg <= `SRW_RESET_BYTE;
      st.regs.waveformKind <= `SRW_RESET_WORD;
      st.regs.channelOutputControl <= `SRW_RESET_WORD;
      st.regs.matchRequestFlags <= `SRW_RESET_BYTE;
      st.regs.flagMask <= `SRW_RESET_BYTE;
      st.regs.portData <= `SRW_RESET_BYTE;
      st.regs.portDir <= `SRW_RESET_BYTE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata = st.rdata;
  assign comparePinOut = st.pins.out;
  assign comparePinOe = st.pins.oe;
  assign irq = st.irq;

endmodule : sr_wave_output

`default_nettype wire

// file: verilog/sr_wave_params.svh
// How it works
// [R1] Even match sets even pin high
// [R2] Paired odd match returns even pin low
// [R3] No reset bits: free run, 65536 period
// [R4] High width equals odd minus even value
// [R5] Channel zero or reload match clears timer
// [R6] Software keeps match values 0001h to FFFDh
// [R7] Software keeps odd value above even value
// [R8] Channel zero reset disables pair zero
// [R9] Both enables start, both cleared stop; code also stops the pair when only one enable is cleared
// [R10] Each match raises its request flag; code does so for enabled channels only
// [R11] Start level and inversion per channel
// [R12] Waveform on even pin, odd pin port
// [R13] Enable and select decide pin role
// [R14] Enabled, select 0, mode 01 means set/reset
// [R15] Timer counts up each count clock
`ifndef SR_WAVE_PARAMS_SVH
`define SR_WAVE_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define SRW_OFS_TIMER_CTRL 5'h00
`define SRW_OFS_RESET_VALUE 5'h01
`define SRW_OFS_FUNC_EN 5'h02
`define SRW_OFS_FUNC_SEL 5'h03
`define SRW_OFS_MODE 5'h04
`define SRW_OFS_OUT_CTRL 5'h05
`define SRW_OFS_FLAGS 5'h06
`define SRW_OFS_MASK 5'h07
`define SRW_OFS_TIMER 5'h08
`define SRW_OFS_PORT_DATA 5'h09
`define SRW_OFS_PORT_DIR 5'h0A
`define SRW_OFS_PIN_IN 5'h0B
`define SRW_OFS_MATCH_BASE 5'h10

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define SRW_CTRL_RST_CH0 0
`define SRW_CTRL_RST_MID 1
`define SRW_CTRL_RST_RELOAD 2
`define SRW_CTRL_COUNT_EN 3
`define SRW_OUT_FLIP_LSB 8
`define SRW_MODE_SR 2'h1

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define SRW_RESET_CTRL 4'h0
`define SRW_RESET_WORD 16'h0000
`define SRW_RESET_BYTE 8'h00

////////////////////////////////////////////////////////////////////////////////
// Timing
`define SRW_PRESCALE_DEFAULT 16'h0001

`endif

// file: verilog/sr_wave_pkg.sv
package sr_wave_pkg;

  typedef enum logic [1:0] {
    SRC_FREE,
    SRC_CH0,
    SRC_RELOAD
  } reset_src_t;

  typedef struct packed {
    logic countEnable;
    logic resetOnReloadMatch;
    logic resetSelectMid;
    logic resetOnChannelZero;
  } timer_ctrl_t;

  typedef struct packed {
    logic [7:0] polarityFlip;
    logic [7:0] startLevelSelect;
  } out_ctrl_t;

  typedef struct packed {
    logic run;
    logic level;
  } pair_state_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  typedef struct packed {
    timer_ctrl_t timerControl;
    logic [15:0] timerResetValue;
    logic [7:0] channelFunctionEnables;
    logic [7:0] functionSelectReg;
    logic [15:0] waveformKind;
    out_ctrl_t channelOutputControl;
    logic [7:0] matchRequestFlags;
    logic [7:0] flagMask;
    logic [7:0] portData;
    logic [7:0] portDir;
    logic [7:0][15:0] matchValue;
  } regs_t;

  typedef struct packed {
    regs_t regs;
    logic [15:0] timer;
    logic [15:0] divCount;
    logic [7:0] pinSync1;
    logic [7:0] pinSync2;
    pin_drive_t pins;
    logic irq;
    logic [15:0] rdata;
  } state_t;

endpackage : sr_wave_pkg

// file: verilog/sr_pair.sv
`timescale 1ns/1ps
`default_nettype none

module sr_pair (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [15:0] timer,
  input wire logic [15:0] evenMatchValue,
  input wire logic [15:0] oddMatchValue,
  input wire logic evenEnable,
  input wire logic oddEnable,
  input wire logic srSelected,
  input wire logic startLevel,
  output logic evenHit,
  output logic oddHit,
  output logic run,
  output logic level
);

  sr_wave_pkg::pair_state_t st;
  sr_wave_pkg::pair_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare on each count clock
  assign evenHit = tick && (timer == evenMatchValue); // see [R10]
  assign oddHit = tick && (timer == oddMatchValue); // see [R10]
  assign run = st.run;
  assign level = st.level;

  ////////////////////////////////////////////////////////////////////////////////
  // Start, stop and edges
  always_comb begin
    next_st = st;
    if (!srSelected || (!evenEnable && !oddEnable)) begin
      next_st.run = 1'b0; // see [R9]
      next_st.level = startLevel; // see [R11]
    end else if (evenEnable && oddEnable && !st.run) begin
      next_st.run = 1'b1; // see [R9]
      next_st.level = startLevel; // see [R11]
    end else if (st.run) begin
      if (oddHit) begin
        next_st.level = 1'b0; // see [R2] [R4]
      end else if (evenHit) begin
        next_st.level = 1'b1; // see [R1] [R4]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : sr_pair

`default_nettype wire

// file: test/sr_wave_output_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sr_wave_output_chk #(
  parameter logic [15:0] PRESCALE = 16'h0001
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [15:0] rdata,
  input wire logic [7:0] comparePinIn,
  input wire logic [7:0] comparePinOut,
  input wire logic [7:0] comparePinOe,
  input wire logic irq
);
  logic [15:0] dirQ, dataQ, m0, m1;
  logic [2:0] rstSel;
  logic [1:0] age;
  logic [16:0] hiCnt;
  logic wrFm;
  logic rdUnmapped;
  assign wrFm = writeStrobe && (addr == 5'h06 || addr == 5'h07);
  assign rdUnmapped = readStrobe && (addr[4:2] == 3'h3 || addr[4:3] == 2'h3);
  // Shadow of the settings the checks need
  always_ff @(posedge clk) begin
    if (rst) begin
      dirQ <= 16'h0000;
      dataQ <= 16'h0000;
      m0 <= 16'h0000;
      m1 <= 16'h0000;
      rstSel <= 3'h0;
      age <= 2'h0;
      hiCnt <= 17'h00000;
    end else begin
      age <= writeStrobe ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
      hiCnt <= (comparePinOut[0] && comparePinOe[0]) ? hiCnt + 17'h00001 : 17'h00000;
      if (writeStrobe && addr == 5'h0A) dirQ <= wdata;
      if (writeStrobe && addr == 5'h09) dataQ <= wdata;
      if (writeStrobe && addr == 5'h10) m0 <= wdata;
      if (writeStrobe && addr == 5'h11) m1 <= wdata;
      if (writeStrobe && addr == 5'h00) rstSel <= wdata[2:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence pulseEnd;
    $fell(comparePinOut[0]) ##0 comparePinOe[0] ##0 $past(comparePinOe[0]);
  endsequence
  chk_rdata_idle: assert property (!$past(readStrobe) |-> rdata == 16'h0000)
    else $error("read data outside a read");
  chk_unmapped_zero: assert property ($past(rdUnmapped) |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($past(rst) |-> {comparePinOut, comparePinOe, irq} == 17'h00000)
    else $error("outputs busy after reset");
  chk_odd_port: assert property (age == 2'h3 |-> ((comparePinOe ^ dirQ[7:0]) & 8'hAA) == 8'h00
    && ((comparePinOut ^ dataQ[7:0]) & 8'hAA) == 8'h00)
    else $error("odd pin not a port");
  chk_chzero_off: assert property (age == 2'h3 && rstSel == 3'h1
    |-> comparePinOe[0] == dirQ[0] && comparePinOut[0] == dataQ[0])
    else $error("pair zero runs with channel zero reset");
  chk_pulse_width: assert property (pulseEnd |-> hiCnt == ({1'b0, m1} - {1'b0, m0}) * PRESCALE)
    else $error("pulse width wrong");
  chk_irq_cause: assert property ($fell(irq) |-> $past(wrFm) || $past(wrFm, 2))
    else $error("irq dropped without a write");
  chk_start_cause: assert property ((comparePinOe & ~$past(comparePinOe)) != 8'h00
    |-> $past(writeStrobe) || $past(writeStrobe, 2) || $past(writeStrobe, 3))
    else $error("pin drive began without a write");
endmodule : sr_wave_output_chk
bind sr_wave_output sr_wave_output_chk #(.PRESCALE(PRESCALE)) chk (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
  .rdata(rdata), .comparePinIn(comparePinIn), .comparePinOut(comparePinOut),
  .comparePinOe(comparePinOe), .irq(irq));
`default_nettype wire

// file: test/test_sr_wave_output.sv
`timescale 1ns/1ps
`default_nettype none
module test_sr_wave_output;
  logic clk;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic [7:0] comparePinIn = 8'hA5;
  logic [15:0] rdata, t0, t1, n;
  logic [7:0] comparePinOut, comparePinOe;
  logic irq;
  int numErrors = 0;
  int nTests = 0;
  int cycles = 0;
  sr_wave_output #(.PRESCALE(16'h0001)) dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .rdata(rdata),
    .comparePinIn(comparePinIn), .comparePinOut(comparePinOut),
    .comparePinOe(comparePinOe), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic stopTest;
    $display("errors %0d checks %0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stopTest
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      numErrors = numErrors + 1;
      stopTest();
    end
  end
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    nTests++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      numErrors++;
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    writeStrobe <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    writeStrobe <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    readStrobe <= 1'b1;
    addr <= a;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1;
    v = rdata;
  endtask : rd
  task automatic rdChk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    check(v, e);
  endtask : rdChk
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic waitPin(input int i, input logic v, output logic [15:0] k);
    k = 16'h0000;
    while (comparePinOut[i] !== v && k < 16'h07D0) begin
      @(posedge clk);
      #1;
      k = k + 16'h0001;
    end
  endtask : waitPin
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values, read-only and unmapped places
    rdChk(5'h00, 16'h0000);
    rdChk(5'h06, 16'h0000);
    rdChk(5'h07, 16'h0000);
    wr(5'h0C, 16'hFFFF);
    rdChk(5'h0C, 16'h0000);
    rdChk(5'h1F, 16'h0000);
    wr(5'h08, 16'h1234);
    rdChk(5'h08, 16'h0000);
    rdChk(5'h0B, 16'h00A5);
    // Free running timer
    wr(5'h00, 16'h0008);
    rd(5'h08, t0);
    rd(5'h08, t1);
    check(t1, t0 + 16'h0002);
    repeat (65532) @(posedge clk);
    rd(5'h08, t1);
    check(t1, t0);
    // Pair zero in reload reset mode
    wr(5'h0A, 16'h00AA);
    wr(5'h09, 16'h00AA);
    wr(5'h10, 16'h0100);
    wr(5'h11, 16'h0180);
    wr(5'h12, 16'h0040);
    wr(5'h13, 16'h0060);
    wr(5'h19, 16'hFFFF);
    rdChk(5'h18, 16'h0000);
    rdChk(5'h11, 16'h0180);
    wr(5'h01, 16'h01FE);
    wr(5'h00, 16'h000C);
    wr(5'h04, 16'h0055);
    wr(5'h03, 16'h0000);
    wr(5'h02, 16'h0003);
    waitPin(0, 1'b1, n);
    check({13'h0000, comparePinOe[1:0], comparePinOut[1]}, 16'h0007);
    waitPin(0, 1'b0, n);
    check(n, 16'h0080);
    waitPin(0, 1'b1, n);
    check(n, 16'h0180);
    // Flags and interrupt
    rdChk(5'h06, 16'h0003);
    check({15'h0000, irq}, 16'h0000);
    wr(5'h07, 16'h0001);
    settle();
    check({15'h0000, irq}, 16'h0001);
    wr(5'h06, 16'h0001);
    settle();
    check({15'h0000, irq}, 16'h0000);
    rdChk(5'h06, 16'h0002);
    wr(5'h07, 16'h0000);
    // Pair one: start level, low time, inversion, stop
    wr(5'h05, 16'h0004);
    wr(5'h02, 16'h000F);
    settle();
    check({14'h0000, comparePinOe[2], comparePinOut[2]}, 16'h0003);
    waitPin(2, 1'b0, n);
    waitPin(2, 1'b1, n);
    check(n, 16'h01E0);
    wr(5'h05, 16'h0404);
    settle();
    check({14'h0000, comparePinOe[2], comparePinOut[2]}, 16'h0002);
    wr(5'h02, 16'h0003);
    settle();
    check({15'h0000, comparePinOe[2]}, 16'h0000);
    // Pin role by select and mode
    wr(5'h03, 16'h0001);
    settle();
    check({14'h0000, comparePinOe[0], comparePinOut[0]}, 16'h0000);
    wr(5'h03, 16'h0000);
    wr(5'h04, 16'h0054);
    settle();
    check({15'h0000, comparePinOe[0]}, 16'h0000);
    wr(5'h04, 16'h0055);
    // Channel zero clears the timer
    wr(5'h00, 16'h0009);
    settle();
    check({15'h0000, comparePinOe[0]}, 16'h0000);
    repeat (300) @(posedge clk);
    rd(5'h08, t0);
    check({15'h0000, t0 <= 16'h0101}, 16'h0001);
    // Mixed reset bits run free
    wr(5'h00, 16'h000B);
    repeat (300) @(posedge clk);
    rd(5'h08, t1);
    check(t1, t0 + 16'h0130);
    stopTest();
  end
endmodule : test_sr_wave_output
`default_nettype wire
